/* design/monitor_pkg.sv */
/*
 Shared constants of the power monitor register bank: pointer values,
 configuration field positions, values after reset and timing counts.
 Assumes the one system clock mclk at 250 MHz.
*/
package monitor_pkg;
    // Pointer values of the six registers
    localparam logic [7:0] PTR_CFG   = 8'h00;
    localparam logic [7:0] PTR_SHUNT = 8'h01;
    localparam logic [7:0] PTR_RAIL  = 8'h02;
    localparam logic [7:0] PTR_POWER = 8'h03;
    localparam logic [7:0] PTR_CUR   = 8'h04;
    localparam logic [7:0] PTR_CAL   = 8'h05;
    // Values after reset
    localparam logic [15:0] CFG_RESET = 16'h399f;
    localparam logic [15:0] RES_RESET = 16'h0000;
    localparam logic [15:0] CAL_RESET = 16'h0000;
    // Configuration field positions
    localparam int SOFT_RESET_BIT = 15;
    localparam int UNUSED_BIT     = 14;
    localparam int RANGE_BIT      = 13;
    localparam int GAIN_HI_BIT    = 12;
    localparam int GAIN_LO_BIT    = 11;
    localparam int RAIL_CONV_LSB  = 7;
    localparam int SHUNT_CONV_LSB = 3;
    localparam int MODE_LSB       = 0;
    // Bus result: conversion ready flag position and rail code position
    localparam int READY_BIT      = 1;
    localparam int RAIL_CODE_LSB  = 3;
    // Result limits in counts
    localparam logic [15:0] SHUNT_LIMIT_G1 = 16'h0fa0;
    localparam logic [12:0] RAIL_MAX_16V   = 13'h0fa0;
    localparam logic [12:0] RAIL_MAX_32V   = 13'h1f40;
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned UPDATE_NS     = 4000;
    localparam int unsigned UPDATE_CYC    = (UPDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          DLY_W         = 10;
    localparam int unsigned CONV_NS [12]  = '{84000, 148000, 276000, 532000, 532000,
        1060000, 2130000, 4260000, 8510000, 17020000, 34050000, 68100000};
    localparam int unsigned CONV_CYC [12] = '{
        CONV_NS[0] / CLK_PERIOD_NS, CONV_NS[1] / CLK_PERIOD_NS, CONV_NS[2] / CLK_PERIOD_NS,
        CONV_NS[3] / CLK_PERIOD_NS, CONV_NS[4] / CLK_PERIOD_NS, CONV_NS[5] / CLK_PERIOD_NS,
        CONV_NS[6] / CLK_PERIOD_NS, CONV_NS[7] / CLK_PERIOD_NS, CONV_NS[8] / CLK_PERIOD_NS,
        CONV_NS[9] / CLK_PERIOD_NS, CONV_NS[10] / CLK_PERIOD_NS,
        CONV_NS[11] / CLK_PERIOD_NS};
endpackage

/* design/serial_target.sv */
/*
 Two-wire serial target: byte engine with start/stop detection, address
 match, acknowledge and byte shifting. Pins are asynchronous and pass two
 flip-flops; data bytes for reads come from the bank in the same clock.
*/
`timescale 1ns/1ps
module serial_target
    import monitor_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // Pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Byte side
    input  wire logic [6:0] dev_addr,
    input  wire logic [7:0] tx_byte,
    output logic            tx_taken,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            start_seen,
    output logic            stop_seen
);
    typedef enum logic [2:0] {T_IDLE, T_ADDR, T_AACK, T_WRITE, T_WACK, T_READ, T_RACK,
        T_SKIP} tstate_t;
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic       scl_p;
        logic       sda_p;
        tstate_t    st;
        logic [7:0] sr;
        logic [3:0] cnt;
        logic       rw;
        logic       oe;
        logic       taken;
        logic       rxv;
        logic       sta;
        logic       sto;
    } target_t;
    target_t q, d;
    logic rise, fall, start_c, stop_c;

    // Edge and condition detection on the second synchroniser stage
    assign rise    = q.scl_s[1] & ~q.scl_p;
    assign fall    = ~q.scl_s[1] & q.scl_p;
    assign start_c = q.scl_s[1] & q.scl_p & q.sda_p & ~q.sda_s[1];
    assign stop_c  = q.scl_s[1] & q.scl_p & ~q.sda_p & q.sda_s[1];

    // Bit engine
    always_comb begin
        d       = q;
        d.scl_s = {q.scl_s[0], scl_in};
        d.sda_s = {q.sda_s[0], sda_in};
        d.scl_p = q.scl_s[1];
        d.sda_p = q.sda_s[1];
        d.taken = 1'b0;
        d.rxv   = 1'b0;
        d.sta   = start_c;
        d.sto   = stop_c;
        if (start_c) begin
            d.st  = T_ADDR;
            d.cnt = '0;
            d.oe  = 1'b0;
        end else if (stop_c) begin
            d.st = T_IDLE;
            d.oe = 1'b0;
        end else if (rise) begin
            if (q.st == T_ADDR || q.st == T_WRITE) begin
                d.sr  = {q.sr[6:0], q.sda_s[1]};
                d.cnt = q.cnt + 4'h1;
            end else if (q.st == T_RACK && q.sda_s[1]) begin
                d.st = T_SKIP;                     // Host ended the read
            end
        end else if (fall) begin
            unique case (q.st)
                T_ADDR: if (q.cnt == 4'h8) begin
                    if (q.sr[7:1] == dev_addr) begin
                        d.st = T_AACK;
                        d.oe = 1'b1;
                        d.rw = q.sr[0];
                    end else begin
                        d.st = T_SKIP;
                    end
                end
                T_AACK, T_RACK: if (q.rw) begin
                    d.st    = T_READ;
                    d.taken = 1'b1;
                    d.oe    = ~tx_byte[7];
                    d.sr    = {tx_byte[6:0], 1'b1};
                    d.cnt   = 4'h1;
                end else begin
                    d.st  = T_WRITE;
                    d.oe  = 1'b0;
                    d.cnt = '0;
                end
                T_WRITE: if (q.cnt == 4'h8) begin
                    d.st  = T_WACK;
                    d.oe  = 1'b1;
                    d.rxv = 1'b1;
                end
                T_WACK: begin
                    d.st  = T_WRITE;
                    d.oe  = 1'b0;
                    d.cnt = '0;
                end
                T_READ: if (q.cnt == 4'h8) begin
                    d.st = T_RACK;
                    d.oe = 1'b0;
                end else begin
                    d.oe  = ~q.sr[7];
                    d.sr  = {q.sr[6:0], 1'b1};
                    d.cnt = q.cnt + 4'h1;
                end
                T_IDLE, T_SKIP: d.oe = 1'b0;
            endcase
        end
    end

    // State register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q <= '{scl_s: 2'h3, sda_s: 2'h3, scl_p: 1'b1, sda_p: 1'b1, st: T_IDLE,
                default: '0};
        end else begin
            q <= d;
        end
    end

    assign sda_out    = 1'b0;                      // Open drain: only ever pulls low
    assign sda_oe     = q.oe;
    assign tx_taken   = q.taken;
    assign rx_valid   = q.rxv;
    assign rx_data    = q.sr;
    assign start_seen = q.sta;
    assign stop_seen  = q.sto;
endmodule // serial_target

/* design/conversion_pacer.sv */
/*
 Conversion pacer: times one shunt and/or rail conversion sequence and
 pulses when each result is due. Cycle counts come from the bank.
*/
`timescale 1ns/1ps
module conversion_pacer (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Control
    input  wire logic        abort,
    input  wire logic        start,
    input  wire logic        do_shunt,
    input  wire logic        do_rail,
    input  wire logic [31:0] shunt_cyc,
    input  wire logic [31:0] rail_cyc,
    // Events
    output logic             shunt_done,
    output logic             rail_done,
    output logic             seq_done,
    output logic             busy
);
    typedef enum logic [1:0] {P_IDLE, P_SHUNT, P_RAIL} pstate_t;
    typedef struct packed {
        pstate_t     st;
        logic [31:0] cnt;
        logic [31:0] rail_cnt;
        logic        rail_next;
        logic        sd;
        logic        rd;
        logic        qd;
    } pacer_t;
    pacer_t q, d;

    // Sequence: shunt first, then rail
    always_comb begin
        d    = q;
        d.sd = 1'b0;
        d.rd = 1'b0;
        d.qd = 1'b0;
        unique case (q.st)
            P_IDLE: if (start && (do_shunt || do_rail)) begin
                d.rail_next = do_rail;
                d.rail_cnt  = rail_cyc - 32'h1;
                d.st        = do_shunt ? P_SHUNT : P_RAIL;
                d.cnt       = (do_shunt ? shunt_cyc : rail_cyc) - 32'h1;
            end
            P_SHUNT: if (q.cnt == '0) begin
                d.sd  = 1'b1;
                d.st  = q.rail_next ? P_RAIL : P_IDLE;
                d.qd  = ~q.rail_next;
                d.cnt = q.rail_cnt;
            end else begin
                d.cnt = q.cnt - 32'h1;
            end
            P_RAIL: if (q.cnt == '0) begin
                d.rd = 1'b1;
                d.qd = 1'b1;
                d.st = P_IDLE;
            end else begin
                d.cnt = q.cnt - 32'h1;
            end
            default: d.st = P_IDLE;                        // Unused code recovers to idle
        endcase
        if (abort) begin
            d.st = P_IDLE;
        end
    end

    // State register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q <= '{st: P_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    assign shunt_done = q.sd;
    assign rail_done  = q.rd;
    assign seq_done   = q.qd;
    assign busy       = (q.st != P_IDLE);
endmodule // conversion_pacer

/* design/power_monitor_register_bank.sv */
/*
 Register bank of a shunt current and power monitor, reached over the
 two-wire serial pins through a pointer. Holds configuration and
 calibration, captures shunt and rail codes from the converter front end
 (same clock domain) and derives current and power.
*/
`timescale 1ns/1ps
// Functional notes
// - Written data takes effect 4 us after the write transaction's stop; a pending word is applied at once when a newer word arrives.
// - Pointer 00..05 selects configuration, shunt, rail, power, current, calibration.
// - Power-on loads configuration with 399f.
// - Power and current read zero after reset and while calibration is zero.
// - Calibration scales the current and power results.
// - Each 16-bit register moves as two bytes, high byte first.
// - Writing one to bit 15 resets every register; the bit self-clears.
// - Range bit selects 16 V (0) or 32 V (1) rail full scale; default one.
// - Gain codes 00..11 give 40, 80, 160, 320 mV shunt range.
// - Shunt gain defaults to divide-by-eight, 320 mV range.
// - Bits 10..7 pick rail resolution or averaging.
// - Bits 6..3 pick shunt resolution or averaging.
// - Top bit zero: low two bits pick 9..12 bit, 84..532 us.
// - Top bit one: 1000 single sample, then 2..128 averages up to 68.10 ms.
// - Mode field: power-down, off, triggered or continuous per channel.
// - Only configuration and calibration accept writes.
// - Shunt result is two's complement, 10 uV counts, clamped to the range of the gain.
module power_monitor_register_bank
    import monitor_pkg::*;
#(
    parameter logic [6:0]  dev_addr_p = 7'h45,           // Target address, arbitrary
    parameter int unsigned conv_cyc_p [12] = CONV_CYC
)(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Serial pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Converter front end codes
    input  wire logic [15:0] shunt_code,
    input  wire logic [12:0] rail_code,
    // Converter front end control
    output logic [1:0]       shunt_gain_field,
    output logic             rail_range_select,
    output logic [3:0]       rail_converter_setting,
    output logic [3:0]       shunt_converter_setting,
    output logic             converter_enable,
    output logic             conv_busy
);
    typedef struct packed {
        logic [15:0]      cfg;
        logic [15:0]      cal;
        logic [15:0]      shunt;
        logic [15:0]      rail;
        logic [15:0]      cur;
        logic [15:0]      pwr;
        logic [7:0]       ptr;
        logic [1:0]       wphase;
        logic [7:0]       msb;
        logic [7:0]       hold_ptr;
        logic [15:0]      hold;
        logic             pend;
        logic             run;
        logic [DLY_W-1:0] dly;
        logic             tx_hi;
        logic             calc;
        logic             kick;
        logic             abort;
        logic             en;
    } bank_t;
    localparam bank_t BANK_RST = '{cfg: CFG_RESET, cal: CAL_RESET, shunt: RES_RESET,
        rail: RES_RESET, cur: RES_RESET, pwr: RES_RESET, ptr: PTR_CFG, tx_hi: 1'b1,
        en: 1'b1, default: '0};
    localparam logic [1:0] WP_PTR = 2'h0;
    localparam logic [1:0] WP_MSB = 2'h1;
    localparam logic [1:0] WP_LSB = 2'h2;

    bank_t q, d;
    logic        tx_taken, rx_valid, start_seen, stop_seen;
    logic [7:0]  rx_data, tx_byte;
    logic        shunt_done, rail_done, seq_done, busy;
    logic [31:0] shunt_cyc, rail_cyc;
    logic [15:0] rd_word;
    logic signed [32:0] cur_prod;
    logic [15:0] cur_w, cur_mag;
    logic [28:0] pwr_prod;

    // Conversion time of a converter setting
    function automatic logic [31:0] conv_cycles(input logic [3:0] s);
        logic [3:0] idx;
        idx = s[3] ? (4'h4 + {1'b0, s[2:0]}) : {2'b00, s[1:0]};
        return 32'(conv_cyc_p[idx]);
    endfunction

    // Mode decode: triggered when the top bit is clear and a channel is on
    function automatic logic is_triggered(input logic [2:0] m);
        return ~m[2] & (m[1:0] != 2'b00);
    endfunction

    // Shunt code clamped to the range of the gain; two's complement keeps sign
    function automatic logic [15:0] fmt_shunt(input logic [15:0] raw, input logic [1:0] g);
        logic signed [15:0] lim;
        logic signed [15:0] v;
        lim = $signed(SHUNT_LIMIT_G1 << g);
        v   = $signed(raw);
        if (v > lim) begin
            v = lim;
        end else if (v < -lim) begin
            v = -lim;
        end
        return v;
    endfunction

    // Apply a committed write to the register image
    function automatic bank_t apply(input bank_t b, input logic [7:0] p,
                                    input logic [15:0] w);
        bank_t r;
        r = b;
        if (p == PTR_CFG) begin
            if (w[SOFT_RESET_BIT]) begin
                r       = BANK_RST;
                r.ptr   = b.ptr;
                r.abort = 1'b1;
            end else begin
                r.cfg              = w;
                r.cfg[UNUSED_BIT]  = 1'b0;
                r.kick             = is_triggered(w[2:0]);
                r.rail[READY_BIT]  = 1'b0;
            end
        end else if (p == PTR_CAL) begin
            r.cal = w;
        end
        return r;
    endfunction

    serial_target u_target (
        .mclk       (mclk),
        .reset      (reset),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .sda_out    (sda_out),
        .sda_oe     (sda_oe),
        .dev_addr   (dev_addr_p),
        .tx_byte    (tx_byte),
        .tx_taken   (tx_taken),
        .rx_valid   (rx_valid),
        .rx_data    (rx_data),
        .start_seen (start_seen),
        .stop_seen  (stop_seen)
    );

    assign shunt_cyc = conv_cycles(q.cfg[SHUNT_CONV_LSB +: 4]);
    assign rail_cyc  = conv_cycles(q.cfg[RAIL_CONV_LSB +: 4]);

    conversion_pacer u_pacer (
        .mclk       (mclk),
        .reset      (reset),
        .abort      (q.abort),
        .start      (q.kick),
        .do_shunt   (q.cfg[MODE_LSB]),
        .do_rail    (q.cfg[MODE_LSB + 1]),
        .shunt_cyc  (shunt_cyc),
        .rail_cyc   (rail_cyc),
        .shunt_done (shunt_done),
        .rail_done  (rail_done),
        .seq_done   (seq_done),
        .busy       (busy)
    );

    // Read multiplexer by pointer; unmapped pointers read zero
    always_comb begin
        unique case (q.ptr)
            PTR_CFG:   rd_word = q.cfg;
            PTR_SHUNT: rd_word = q.shunt;
            PTR_RAIL:  rd_word = q.rail;
            PTR_POWER: rd_word = q.pwr;
            PTR_CUR:   rd_word = q.cur;
            PTR_CAL:   rd_word = q.cal;
            default:   rd_word = 16'h0000;
        endcase
        tx_byte = q.tx_hi ? rd_word[15:8] : rd_word[7:0];
    end

    // Current and power from the latest shunt and rail results
    always_comb begin
        cur_prod = $signed(q.shunt) * $signed({1'b0, q.cal});
        cur_w    = cur_prod[27:12];
        cur_mag  = cur_w[15] ? 16'(-cur_w) : cur_w;
        pwr_prod = cur_mag * q.rail[15:RAIL_CODE_LSB];
    end

    // Register bank update
    always_comb begin
        d       = q;
        d.kick  = 1'b0;
        d.abort = 1'b0;
        d.calc  = 1'b0;
        // Byte framing of the serial link
        if (start_seen) begin
            d.wphase = WP_PTR;
            d.tx_hi  = 1'b1;
        end
        if (tx_taken) begin
            d.tx_hi = ~q.tx_hi;
        end
        if (rx_valid) begin
            unique case (q.wphase)
                WP_PTR: begin
                    d.ptr    = rx_data;
                    d.tx_hi  = 1'b1;
                    d.wphase = WP_MSB;
                end
                WP_MSB: begin
                    d.msb    = rx_data;
                    d.wphase = WP_LSB;
                end
                WP_LSB: begin
                    if (q.pend) begin
                        d = apply(d, q.hold_ptr, q.hold);         // Older write goes first
                    end
                    d.hold     = {q.msb, rx_data};
                    d.hold_ptr = q.ptr;
                    d.pend     = 1'b1;
                    d.run      = 1'b0;
                    d.wphase   = WP_MSB;
                end
                default: d.wphase = WP_PTR;
            endcase
        end
        // Delayed commit after the stop condition
        if (stop_seen && q.pend && !q.run) begin
            d.run = 1'b1;
            d.dly = DLY_W'(UPDATE_CYC - 1);
        end else if (q.run && !(rx_valid && q.wphase == WP_LSB)) begin  // Newer pair flushed it
            if (q.dly == '0) begin
                d.run  = 1'b0;
                d.pend = 1'b0;
                d      = apply(d, q.hold_ptr, q.hold);
            end else begin
                d.dly = q.dly - DLY_W'(1);
            end
        end
        // Continuous modes restart the pacer whenever it is idle
        if (q.cfg[2] && q.cfg[1:0] != 2'b00 && !busy && !q.kick && !q.abort) begin
            d.kick = 1'b1;
        end
        d.en = (q.cfg[1:0] != 2'b00);
        // Results from the converter front end
        if (shunt_done) begin
            d.shunt = fmt_shunt(shunt_code, q.cfg[GAIN_HI_BIT:GAIN_LO_BIT]);
            d.calc  = 1'b1;
        end
        if (rail_done) begin
            d.rail[15:RAIL_CODE_LSB] = q.cfg[RANGE_BIT] ?
                ((rail_code > RAIL_MAX_32V) ? RAIL_MAX_32V : rail_code) :
                ((rail_code > RAIL_MAX_16V) ? RAIL_MAX_16V : rail_code);
            d.calc = 1'b1;
        end
        if (seq_done) begin
            d.rail[READY_BIT] = 1'b1;                             // Set wins over clear
        end
        if (q.calc) begin
            d.cur = cur_w;
            d.pwr = pwr_prod[27:12];
        end
    end

    // State register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q <= BANK_RST;
        end else begin
            q <= d;
        end
    end

    // Front end control straight from the configuration register; enable one clock later, busy from the pacer
    assign shunt_gain_field        = q.cfg[GAIN_HI_BIT:GAIN_LO_BIT];
    assign rail_range_select       = q.cfg[RANGE_BIT];
    assign rail_converter_setting  = q.cfg[RAIL_CONV_LSB +: 4];
    assign shunt_converter_setting = q.cfg[SHUNT_CONV_LSB +: 4];
    assign converter_enable        = q.en;
    assign conv_busy               = busy;
endmodule // power_monitor_register_bank

/* sim/power_monitor_chk.sv */
/* Pin checker of the register bank.
   Bound into every bank instance by the statement at the foot. */
`timescale 1ns/1ps
module power_monitor_chk (
    // Clock and reset
    input wire logic       mclk, reset,
    // Pins and converter control
    input wire logic       scl_in, sda_in, sda_out, sda_oe, rail_range_select, conv_busy,
    input wire logic [1:0] shunt_gain_field,
    input wire logic [3:0] rail_converter_setting, shunt_converter_setting
);
    logic        sda_q;
    logic [10:0] since_q;
    // Cycles since the last stop on the raw pins, saturating
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sda_q   <= 1'b1;
            since_q <= '1;
        end else begin
            sda_q <= sda_in;
            if (scl_in && sda_in && !sda_q) since_q <= '0;
            else if (since_q != '1) since_q <= since_q + 11'd1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    a_gain_default: assert property ($fell(reset) |-> shunt_gain_field == 2'b11)
        else $error("gain default");
    a_range_default: assert property ($fell(reset) |-> rail_range_select)
        else $error("range default");
    a_conv_default: assert property ($fell(reset) |->
        {rail_converter_setting, shunt_converter_setting} == 8'h33) else $error("conv default");
    a_busy_kick: assert property ($fell(reset) |-> ##[1:3] conv_busy)
        else $error("no start");
    a_commit_delay: assert property ($changed({shunt_gain_field, rail_range_select,
        rail_converter_setting, shunt_converter_setting}) |-> since_q inside {[1000:1012]})
        else $error("commit time");
    a_open_drain: assert property (sda_out == 1'b0) else $error("sda high");
    a_sda_on_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved");
    a_conv_span: assert property ($rose(conv_busy) && since_q < 11'd990 |=> conv_busy[*8])
        else $error("short conv");
    c_ack: cover property ($rose(sda_oe));
    c_seq: cover property ($fell(conv_busy));
    c_commit: cover property ($changed(shunt_gain_field));
endmodule // power_monitor_chk
bind power_monitor_register_bank power_monitor_chk chk (.mclk, .reset, .scl_in, .sda_in,
    .sda_out, .sda_oe, .rail_range_select, .conv_busy, .shunt_gain_field,
    .rail_converter_setting, .shunt_converter_setting);

/* sim/serial_host.sv */
/* Behavioural two-wire host: start, stop, bytes, pointer writes and reads.
   Assumes an open-drain data wire with pull-up resolved by the bench. */
`timescale 1ns/1ps
module serial_host #(
    parameter logic [6:0] addr_p = 7'h45    // Target address, arbitrary
)(
    // Clock and wire
    input  wire logic mclk,
    input  wire logic sda,
    output logic      scl = 1'b1,
    output logic      sda_low = 1'b0
);
    int nacks = 0;
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Data moves mid-low, sampled mid-high; phases of 10 cycles
    task automatic bit_io(input logic b, output logic r);
        scl <= 1'b0;
        tick(5);
        sda_low <= !b;
        tick(5);
        scl <= 1'b1;
        tick(5);
        r = sda;
        tick(5);
    endtask
    // Eight bits then the acknowledge bit; a target ack is expected on writes
    task automatic byte_io(input logic [7:0] d, input logic ack, input logic wr,
                           output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ack, a);
        if (wr && a) nacks++;
    endtask
    task automatic start_c();
        tick(1);
        sda_low <= 1'b1;
        tick(5);
    endtask
    task automatic stop_c();
        scl <= 1'b0;
        tick(5);
        sda_low <= 1'b1;
        tick(5);
        scl <= 1'b1;
        tick(5);
        sda_low <= 1'b0;
        tick(5);
    endtask
    // Pointer, then a word high byte first when asked
    task automatic wr(input logic [7:0] p, input logic [15:0] w, input logic word);
        logic [7:0] q;
        start_c();
        byte_io({addr_p, 1'b0}, 1'b1, 1'b1, q);
        byte_io(p, 1'b1, 1'b1, q);
        if (word) begin
            byte_io(w[15:8], 1'b1, 1'b1, q);
            byte_io(w[7:0], 1'b1, 1'b1, q);
        end
        stop_c();
    endtask
    task automatic rd(input logic [7:0] p, output logic [15:0] w);
        wr(p, 16'h0000, 1'b0);
        start_c();
        byte_io({addr_p, 1'b1}, 1'b1, 1'b1, w[15:8]);
        byte_io(8'hff, 1'b0, 1'b0, w[15:8]);
        byte_io(8'hff, 1'b1, 1'b0, w[7:0]);
        stop_c();
    endtask
endmodule // serial_host

/* sim/tb_power_monitor_register_bank.sv */
/* Self-checking bench of the register bank over the two-wire pins.
   Assumes the serial_host model and the bound pin checker. */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_power_monitor_register_bank;
    import monitor_pkg::*;
    logic        mclk = 0, reset = 1, scl, host_low, sda_oe, sda_out, rail_range_select;
    logic        converter_enable, conv_busy;
    logic [15:0] shunt_code = 16'h1234, rd_w;
    logic [12:0] rail_code = 13'h0100;
    logic [1:0]  shunt_gain_field;
    logic [3:0]  rail_converter_setting, shunt_converter_setting;
    int          failures = 0, tests_run = 0;
    wire         sda = !(host_low || sda_oe);    // Pulled up unless someone pulls low
    power_monitor_register_bank #(.conv_cyc_p('{20, 24, 28, 32, 36, 40, 44, 48, 52, 56, 60,
        64})) uut (.mclk, .reset, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .shunt_code,
        .rail_code, .shunt_gain_field, .rail_range_select, .rail_converter_setting,
        .shunt_converter_setting, .converter_enable, .conv_busy);
    serial_host host (.mclk, .sda, .scl, .sda_low(host_low));
    initial forever #2 mclk = ~mclk;
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic rchk(input logic [7:0] p, input logic [15:0] e);
        host.rd(p, rd_w);
        `CHK(rd_w, e)
    endtask
    // Main sequence: map, read-only places, settings, calibration, soft reset, modes
    initial begin
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        repeat (200) @(posedge mclk);
        rchk(8'h00, CFG_RESET);
        rchk(8'h01, 16'h1234);
        rchk(8'h02, 16'h0802);
        rchk(8'h03, RES_RESET);
        rchk(8'h04, RES_RESET);
        rchk(8'h05, CAL_RESET);
        rchk(8'h06, 16'h0000);
        for (int p = 1; p <= 4; p++) host.wr(p[7:0], 16'hffff, 1'b1);
        rchk(8'h01, 16'h1234);
        rchk(8'h03, 16'h0000);
        rchk(8'h02, 16'h0802);
        $display("test map done");
        host.wr(8'h00, 16'h4d2f, 1'b1);
        `CHK(shunt_gain_field, 2'b11)
        repeat (1100) @(posedge mclk);
        `CHK({rail_range_select, shunt_gain_field}, 3'b001)
        `CHK({rail_converter_setting, shunt_converter_setting}, 8'ha5)
        shunt_code <= 16'h8300;
        rail_code <= 13'h1fff;
        repeat (300) @(posedge mclk);
        rchk(8'h00, 16'h0d2f);
        rchk(8'h01, 16'he0c0);
        rchk(8'h02, 16'h7d02);
        rchk(8'h04, 16'h0000);
        host.wr(8'h05, 16'h1000, 1'b1);
        repeat (1300) @(posedge mclk);
        rchk(8'h04, 16'he0c0);
        rchk(8'h03, 16'h1e84);
        $display("test settings done");
        host.wr(8'h00, 16'h8000, 1'b1);
        repeat (1100) @(posedge mclk);
        `CHK({rail_range_select, shunt_gain_field}, 3'b111)
        rchk(8'h05, CAL_RESET);
        rchk(8'h00, CFG_RESET);
        $display("test soft reset done");
        for (int m = 0; m < 8; m++) begin
            host.wr(8'h00, 16'h3998 | m[15:0], 1'b1);
            repeat (1100) @(posedge mclk);
            `CHK(converter_enable, m[1:0] != 2'b00)
            if (!m[2] || m[1:0] == 2'b00) `CHK(conv_busy, 1'b0)
        end
        `CHK(host.nacks, 0)
        $display("test modes done");
        close_out();
    end
endmodule // tb_power_monitor_register_bank
